// [src/input_filter_cfg.svh]
// timing and layout constants of the local input filter
// assumes a 100 MHz system clock and a microsecond filter tick
`ifndef INPUT_FILTER_CFG_SVH
`define INPUT_FILTER_CFG_SVH

`define CLK_NS 10
`define TICK_NS 1000
`define TICK_CYC (`TICK_NS / `CLK_NS)
`define TICK_W 7
`define CNT_W 16
`define NUM_IN 12
`define NUM_FAST 3

// filter times in microseconds
`define DC_DEBOUNCE_US 20000
`define DC_ON_FAST_US 25
`define DC_ON_SLOW_US 250
`define DC_OFF_FAST_US 25
`define DC_OFF_LONG_US 400
`define DC_OFF_SHORT_US 200
`define AC_LONG_50_US 40000
`define AC_LONG_60_US 33300
`define AC_SHORT_50_US 20000
`define AC_SHORT_60_US 16700

// input index groups
`define FAST_GROUP_LAST 3
`define OFF_SEL_BIT 1

`endif

// [src/input_filter_pkg.sv]
// types shared by the local input filter and its channel modules
// assumes the constants of input_filter_cfg.svh
`include "input_filter_cfg.svh"

package input_filter_pkg;

  typedef struct packed {
    logic ac_unit;
    logic debounce_en;
    logic mains_60hz;
  } filter_cfg_t;

  typedef struct packed {
    logic [`NUM_IN-1:0] expansion_input_contact;
    logic [`NUM_IN-1:0] local_input_terminal;
  } input_image_t;

  typedef struct packed {
    logic [`CNT_W-1:0] fast_counter_c;
    logic [`CNT_W-1:0] fast_counter_b;
    logic [`CNT_W-1:0] fast_counter_a;
  } fast_counts_t;

endpackage : input_filter_pkg

// [src/dc_level_qualifier.sv]
// one DC input channel: level must hold for a time before the contact follows
// assumes a one-cycle tick pulse every microsecond and limits of at least 1
`timescale 1ns/1ps
`include "input_filter_cfg.svh"

module dc_level_qualifier (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // timing
  input wire logic tick,
  input wire logic [`CNT_W-1:0] on_ticks,
  input wire logic [`CNT_W-1:0] off_ticks,
  // signal
  input wire logic raw,
  output logic filtered
);
  import input_filter_pkg::*;

  typedef struct packed {
    logic filt;
    logic [`CNT_W-1:0] cnt;
  } dc_state_t;

  dc_state_t st;
  dc_state_t next_st;
  logic [`CNT_W-1:0] limit;

  always_comb begin
    next_st = st;
    limit = st.filt ? off_ticks : on_ticks;
    if (raw == st.filt) begin
      // any return to the old level restarts qualification
      next_st.cnt = '0;
    end else if (tick) begin
      if (st.cnt + `CNT_W'(1) >= limit) begin
        next_st.filt = raw;
        next_st.cnt = '0;
      end else begin
        next_st.cnt = st.cnt + `CNT_W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign filtered = st.filt;

endmodule : dc_level_qualifier

// [src/ac_halfwave_scanner.sv]
// one AC input channel: looks for positive half-waves within each scan window
// assumes scan_end pulses once at the end of every scan period
`timescale 1ns/1ps

module ac_halfwave_scanner (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // control
  input wire logic scan_end,
  input wire logic debounce_en,
  // signal
  input wire logic raw,
  output logic filtered
);
  import input_filter_pkg::*;

  typedef struct packed {
    logic filt;
    logic seen;
    logic prev_hit;
  } ac_state_t;

  ac_state_t st;
  ac_state_t next_st;
  logic hit;

  always_comb begin
    next_st = st;
    hit = st.seen | raw;
    next_st.seen = hit;
    if (scan_end) begin
      next_st.seen = 1'b0;
      next_st.prev_hit = hit;
      if (debounce_en) begin
        // two agreeing scans in a row
        if (hit && st.prev_hit) begin
          next_st.filt = 1'b1;
        end else if (!hit && !st.prev_hit) begin
          next_st.filt = 1'b0;
        end
      end else begin
        next_st.filt = hit;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign filtered = st.filt;

endmodule : ac_halfwave_scanner

// [src/input_debounce_filter.sv]
// local input conditioning: DC level qualification or AC half-wave scanning,
// fast pulse counters on raw terminals, and the per-cycle input image
// assumes terminals and control inputs are synchronous to sys_clk and that
// cycle_start is a one-cycle pulse from the program sequencer
`timescale 1ns/1ps
`include "input_filter_cfg.svh"

module input_debounce_filter #(
  parameter logic [`CNT_W-1:0] DC_DEBOUNCE_TICKS = `CNT_W'(`DC_DEBOUNCE_US * 1000 / `TICK_NS),
  parameter logic [`CNT_W-1:0] AC_LONG_50_TICKS = `CNT_W'(`AC_LONG_50_US * 1000 / `TICK_NS),
  parameter logic [`CNT_W-1:0] AC_LONG_60_TICKS = `CNT_W'(`AC_LONG_60_US * 1000 / `TICK_NS),
  parameter logic [`CNT_W-1:0] AC_SHORT_50_TICKS = `CNT_W'(`AC_SHORT_50_US * 1000 / `TICK_NS),
  parameter logic [`CNT_W-1:0] AC_SHORT_60_TICKS = `CNT_W'(`AC_SHORT_60_US * 1000 / `TICK_NS)
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // configuration
  input input_filter_pkg::filter_cfg_t cfg,
  // terminals
  input wire logic [`NUM_IN-1:0] local_input_terminal,
  input wire logic [`NUM_IN-1:0] expansion_input_contact,
  // program cycle
  input wire logic cycle_start,
  output input_filter_pkg::input_image_t image,
  output logic [`NUM_IN-1:0] filtered_now,
  // fast counters
  input wire logic [`NUM_FAST-1:0] counter_clear,
  output input_filter_pkg::fast_counts_t fast_counts
);
  import input_filter_pkg::*;

  localparam logic [`TICK_W-1:0] TICK_LAST = `TICK_W'(`TICK_CYC - 1);
  localparam logic [`CNT_W-1:0] DC_ON_FAST_TICKS = `CNT_W'(`DC_ON_FAST_US * 1000 / `TICK_NS);
  localparam logic [`CNT_W-1:0] DC_ON_SLOW_TICKS = `CNT_W'(`DC_ON_SLOW_US * 1000 / `TICK_NS);
  localparam logic [`CNT_W-1:0] DC_OFF_FAST_TICKS = `CNT_W'(`DC_OFF_FAST_US * 1000 / `TICK_NS);
  localparam logic [`CNT_W-1:0] DC_OFF_LONG_TICKS = `CNT_W'(`DC_OFF_LONG_US * 1000 / `TICK_NS);
  localparam logic [`CNT_W-1:0] DC_OFF_SHORT_TICKS =
    `CNT_W'(`DC_OFF_SHORT_US * 1000 / `TICK_NS);

  typedef struct packed {
    logic [`TICK_W-1:0] tick_div;
    logic [`CNT_W-1:0] scan_cnt;
    logic [`NUM_FAST-1:0] prev_raw;
    fast_counts_t counts;
    input_image_t image;
  } top_state_t;

  top_state_t st;
  top_state_t next_st;
  logic tick;
  logic scan_end;
  logic [`CNT_W-1:0] scan_period;
  logic [`NUM_IN-1:0] dc_filt;
  logic [`NUM_IN-1:0] ac_filt;

  // undebounced on-delay by input position
  function automatic logic [`CNT_W-1:0] dc_on_time(input int unsigned idx, input logic deb);
    if (deb) begin
      dc_on_time = DC_DEBOUNCE_TICKS;
    end else if (idx < `FAST_GROUP_LAST + 1) begin
      dc_on_time = DC_ON_FAST_TICKS;
    end else begin
      dc_on_time = DC_ON_SLOW_TICKS;
    end
  endfunction : dc_on_time

  // undebounced off-delay: pairs 5,6 / 9,10 long, 7,8 / 11,12 short
  function automatic logic [`CNT_W-1:0] dc_off_time(input int unsigned idx, input logic deb);
    logic [31:0] pos;
    pos = 32'(idx);
    if (deb) begin
      dc_off_time = DC_DEBOUNCE_TICKS;
    end else if (idx < `FAST_GROUP_LAST + 1) begin
      dc_off_time = DC_OFF_FAST_TICKS;
    end else if (!pos[`OFF_SEL_BIT]) begin
      dc_off_time = DC_OFF_LONG_TICKS;
    end else begin
      dc_off_time = DC_OFF_SHORT_TICKS;
    end
  endfunction : dc_off_time

  // scan period for the AC path
  function automatic logic [`CNT_W-1:0] ac_period(input logic deb, input logic hz60);
    logic [1:0] sel;
    sel = {deb, hz60};
    case (sel)
      2'h0: begin
        ac_period = AC_SHORT_50_TICKS;
      end
      2'h1: begin
        ac_period = AC_SHORT_60_TICKS;
      end
      2'h2: begin
        ac_period = AC_LONG_50_TICKS;
      end
      default: begin
        ac_period = AC_LONG_60_TICKS;
      end
    endcase
  endfunction : ac_period

  assign tick = (st.tick_div == TICK_LAST);
  assign scan_period = ac_period(cfg.debounce_en, cfg.mains_60hz);
  assign scan_end = tick && (st.scan_cnt + `CNT_W'(1) >= scan_period);

  genvar gi;
  generate
    for (gi = 0; gi < `NUM_IN; gi++) begin : g_chan
      dc_level_qualifier u_dc (
        .sys_clk(sys_clk),
        .rst(rst),
        .tick(tick),
        .on_ticks(dc_on_time(gi, cfg.debounce_en)),
        .off_ticks(dc_off_time(gi, cfg.debounce_en)),
        .raw(local_input_terminal[gi]),
        .filtered(dc_filt[gi])
      );
      // bounce resolves at the next scan boundary, or after two agreeing scans when debounce_en is set
      ac_halfwave_scanner u_ac (
        .sys_clk(sys_clk),
        .rst(rst),
        .scan_end(scan_end),
        .debounce_en(cfg.debounce_en),
        .raw(local_input_terminal[gi]),
        .filtered(ac_filt[gi])
      );
    end
  endgenerate

  assign filtered_now = cfg.ac_unit ? ac_filt : dc_filt;

  always_comb begin
    next_st = st;
    // microsecond tick divider
    next_st.tick_div = tick ? '0 : st.tick_div + `TICK_W'(1);
    // scan window timer, restarted at each scan end
    if (scan_end) begin
      next_st.scan_cnt = '0;
    end else if (tick) begin
      next_st.scan_cnt = st.scan_cnt + `CNT_W'(1);
    end
    // fast counters take raw terminals, bypassing filter and cycle
    next_st.prev_raw = local_input_terminal[`NUM_FAST-1:0];
    if (counter_clear[0]) begin
      next_st.counts.fast_counter_a = '0;
    end else if (local_input_terminal[0] && !st.prev_raw[0]) begin
      next_st.counts.fast_counter_a = st.counts.fast_counter_a + `CNT_W'(1);
    end
    if (counter_clear[1]) begin
      next_st.counts.fast_counter_b = '0;
    end else if (local_input_terminal[1] && !st.prev_raw[1]) begin
      next_st.counts.fast_counter_b = st.counts.fast_counter_b + `CNT_W'(1);
    end
    if (counter_clear[2]) begin
      next_st.counts.fast_counter_c = '0;
    end else if (local_input_terminal[2] && !st.prev_raw[2]) begin
      next_st.counts.fast_counter_c = st.counts.fast_counter_c + `CNT_W'(1);
    end
    // image loads only at cycle start and holds otherwise
    if (cycle_start) begin
      next_st.image.local_input_terminal = filtered_now;
      next_st.image.expansion_input_contact = expansion_input_contact;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign image = st.image;
  assign fast_counts = st.counts;

endmodule : input_debounce_filter

// [dv/field_switches.sv]
// field switches and pushbuttons on the local input terminals
// assumes a 100 MHz sys_clk; the mains period is shrunk to 8 us, so each half-wave lasts 4 us
`timescale 1ns/1ps
`include "input_filter_cfg.svh"

module field_switches (
  // clock
  input wire logic sys_clk,
  // switch positions
  input wire logic [`NUM_IN-1:0] want,
  input wire logic ac_mode,
  input wire logic bounce,
  // terminals
  output logic [`NUM_IN-1:0] terminal
);
  logic [9:0] phase = 10'h000;
  logic [8:0] settle = 9'h000;
  logic [`NUM_IN-1:0] last = '0;

  always_ff @(posedge sys_clk) begin
    phase <= (phase == 10'h31F) ? 10'h000 : phase + 10'h001;
    last <= want;
    settle <= (want != last) ? 9'h12C : ((settle != 9'h000) ? settle - 9'h001 : 9'h000);
  end

  always_comb begin
    terminal = ac_mode ? (want & {`NUM_IN{phase < 10'h190}}) : want;
    if (bounce && settle != 9'h000) begin
      terminal = terminal & {`NUM_IN{settle[5]}};
    end
  end
endmodule : field_switches

// [dv/filter_properties.sv]
// port checker of the local input filter
// assumes a 100 MHz sys_clk and a 1 us filter tick
`timescale 1ns/1ps
`include "input_filter_cfg.svh"

module filter_properties #(
  parameter logic [`CNT_W-1:0] DC_DEBOUNCE_TICKS = 16'h4E20
) (
  input wire logic sys_clk,
  input wire logic rst,
  input input_filter_pkg::filter_cfg_t cfg,
  input wire logic [`NUM_IN-1:0] local_input_terminal,
  input wire logic [`NUM_IN-1:0] expansion_input_contact,
  input wire logic cycle_start,
  input input_filter_pkg::input_image_t image,
  input wire logic [`NUM_IN-1:0] filtered_now,
  input wire logic [`NUM_FAST-1:0] counter_clear,
  input input_filter_pkg::fast_counts_t fast_counts
);
  import input_filter_pkg::*;
  int hi_cnt;
  int lo_cnt;
  int min_cnt;
  assign min_cnt = cfg.debounce_en ? int'(DC_DEBOUNCE_TICKS) * 100 - 100 : 2400;
  always_ff @(posedge sys_clk) begin
    hi_cnt <= (rst || !local_input_terminal[0]) ? 0 : hi_cnt + 1;
    lo_cnt <= (rst || local_input_terminal[0]) ? 0 : lo_cnt + 1;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  image_hold_a: assert property (!cycle_start |=> $stable(image))
    else $error("image changed outside cycle start");
  image_local_a: assert property (cycle_start |=>
    image.local_input_terminal == $past(filtered_now))
    else $error("image local part wrong");
  image_exp_a: assert property (cycle_start |=>
    image.expansion_input_contact == $past(expansion_input_contact))
    else $error("image expansion part wrong");
  reset_clear_a: assert property (disable iff (1'b0) rst |=>
    (image == '0 && fast_counts == '0 && filtered_now == '0))
    else $error("outputs not cleared by reset");
  count_step_a: assert property ($rose(local_input_terminal[0]) && !counter_clear[0] |=>
    fast_counts.fast_counter_a == $past(fast_counts.fast_counter_a) + 16'h0001)
    else $error("fast counter a missed an edge");
  count_clear_a: assert property (counter_clear[0] |=>
    fast_counts.fast_counter_a == 16'h0000)
    else $error("fast counter a not cleared");
  dc_rise_a: assert property ($rose(filtered_now[0]) && !cfg.ac_unit |-> hi_cnt >= min_cnt)
    else $error("dc contact rose too early");
  dc_fall_a: assert property ($fell(filtered_now[0]) && !cfg.ac_unit |-> lo_cnt >= min_cnt)
    else $error("dc contact fell too early");

  cover property (cycle_start ##1 image != '0);
  cover property (cfg.ac_unit && cfg.debounce_en && $rose(filtered_now[0]));
  cover property (counter_clear[0] && fast_counts.fast_counter_a != 16'h0000);
endmodule : filter_properties

bind input_debounce_filter filter_properties #(.DC_DEBOUNCE_TICKS(DC_DEBOUNCE_TICKS))
  filter_properties_i (.sys_clk(sys_clk), .rst(rst), .cfg(cfg),
  .local_input_terminal(local_input_terminal), .expansion_input_contact(expansion_input_contact),
  .cycle_start(cycle_start), .image(image), .filtered_now(filtered_now),
  .counter_clear(counter_clear), .fast_counts(fast_counts));

// [dv/testbench.sv]
// self-checking bench of the local input filter
// assumes shortened tick parameters and the field switch model
`timescale 1ns/1ps
`include "input_filter_cfg.svh"

module testbench;
  import input_filter_pkg::*;
  localparam int DEB = 20;
  localparam int LONG50 = 20;
  localparam int LONG60 = 17;
  localparam int SHORT50 = 10;
  localparam int SHORT60 = 8;
  logic sys_clk;
  logic rst;
  logic cycle_start;
  logic bounce;
  filter_cfg_t cfg;
  logic [`NUM_IN-1:0] want;
  logic [`NUM_IN-1:0] terminal;
  logic [`NUM_IN-1:0] expansion;
  logic [`NUM_IN-1:0] filtered_now;
  logic [`NUM_FAST-1:0] counter_clear;
  input_image_t image;
  fast_counts_t fast_counts;
  int miscompares = 0;
  int n_checks = 0;

  field_switches field_switches_i (.sys_clk(sys_clk), .want(want), .ac_mode(cfg.ac_unit),
    .bounce(bounce), .terminal(terminal));
  input_debounce_filter #(.DC_DEBOUNCE_TICKS(16'h0014), .AC_LONG_50_TICKS(16'h0014),
    .AC_LONG_60_TICKS(16'h0011), .AC_SHORT_50_TICKS(16'h000A), .AC_SHORT_60_TICKS(16'h0008))
  input_debounce_filter_i (.sys_clk(sys_clk), .rst(rst), .cfg(cfg),
    .local_input_terminal(terminal), .expansion_input_contact(expansion),
    .cycle_start(cycle_start), .image(image), .filtered_now(filtered_now),
    .counter_clear(counter_clear), .fast_counts(fast_counts));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic wrap_up;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up

  task automatic check(logic [47:0] seen, logic [47:0] exp, string what);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic ticks(int n);
    repeat (n * 100) @(negedge sys_clk);
  endtask : ticks

  task automatic restart(logic ac, logic deb, logic hz60);
    @(negedge sys_clk);
    rst = 1'b1;
    cfg = '{ac, deb, hz60};
    want = '0;
    repeat (5) @(negedge sys_clk);
    rst = 1'b0;
  endtask : restart

  task automatic pulse_start;
    // one short program cycle per call
    cycle_start = 1'b1;
    @(negedge sys_clk);
    cycle_start = 1'b0;
  endtask : pulse_start

  task automatic wait_bit(int idx, logic v, int lo, int hi, string what);
    int c;
    c = 0;
    while (filtered_now[idx] !== v && c < hi * 100) begin
      @(negedge sys_clk);
      c++;
    end
    check(filtered_now[idx], v, what);
    check(c >= lo * 100, 1, {what, " delay"});
  endtask : wait_bit

  task automatic dc_debounce;
    restart(1'b0, 1'b1, 1'b0);
    want[0] = 1'b1;
    ticks(DEB - 5);
    want[0] = 1'b0;
    ticks(5);
    check(filtered_now[0], 1'b0, "glitch");
    want[0] = 1'b1;
    wait_bit(0, 1'b1, DEB - 1, DEB + 2, "dc rise");
    want[0] = 1'b0;
    wait_bit(0, 1'b0, DEB - 1, DEB + 2, "dc fall");
    expansion = 12'h5A3;
    pulse_start;
    check(image, {12'h5A3, 12'h000}, "image expansion");
  endtask : dc_debounce

  task automatic dc_fast;
    restart(1'b0, 1'b0, 1'b0);
    want = 12'hFFF;
    ticks(27);
    check(filtered_now, 12'h00F, "dc on 1-4");
    ticks(226);
    check(filtered_now, 12'hFFF, "dc on 5-12");
    expansion = 12'h3C6;
    pulse_start;
    check(image, {12'h3C6, 12'hFFF}, "image load");
    want = '0;
    expansion = '0;
    ticks(27);
    check(filtered_now, 12'hFF0, "dc off 1-4");
    check(image, {12'h3C6, 12'hFFF}, "image held");
    ticks(176);
    check(filtered_now, 12'h330, "dc off short");
    ticks(200);
    check(filtered_now, 12'h000, "dc off long");
  endtask : dc_fast

  task automatic counters;
    restart(1'b0, 1'b0, 1'b0);
    repeat (3) begin
      want[0] = 1'b1;
      @(negedge sys_clk);
      want[0] = 1'b0;
      @(negedge sys_clk);
    end
    want[2:1] = 2'h3;
    repeat (2) @(negedge sys_clk);
    check(fast_counts, {16'h0001, 16'h0001, 16'h0003}, "fast counts");
    counter_clear = 3'b001;
    @(negedge sys_clk);
    counter_clear = 3'b000;
    check(fast_counts, {16'h0001, 16'h0001, 16'h0000}, "count clear");
  endtask : counters

  task automatic ac_scan;
    restart(1'b1, 1'b0, 1'b0);
    want[0] = 1'b1;
    wait_bit(0, 1'b1, SHORT50 - 1, SHORT50 + 2, "ac short on");
    want[0] = 1'b0;
    wait_bit(0, 1'b0, SHORT50 - 1, SHORT50 + 2, "ac short off");
    restart(1'b1, 1'b0, 1'b1);
    want[0] = 1'b1;
    wait_bit(0, 1'b1, SHORT60 - 1, SHORT60 + 2, "ac short 60 on");
    restart(1'b1, 1'b0, 1'b0);
    bounce = 1'b1;
    want[0] = 1'b1;
    wait_bit(0, 1'b1, SHORT50 - 1, 2 * SHORT50 + 2, "ac bounce on");
    bounce = 1'b0;
  endtask : ac_scan

  task automatic ac_long;
    restart(1'b1, 1'b1, 1'b1);
    want[0] = 1'b1;
    wait_bit(0, 1'b1, 2 * LONG60 - 1, 2 * LONG60 + 2, "ac long on");
    want[0] = 1'b0;
    wait_bit(0, 1'b0, 2 * LONG60 - 1, 2 * LONG60 + 2, "ac long off");
    restart(1'b1, 1'b1, 1'b0);
    want[0] = 1'b1;
    wait_bit(0, 1'b1, 2 * LONG50 - 1, 2 * LONG50 + 2, "ac long 50 on");
  endtask : ac_long

  initial begin
    rst = 1'b1;
    cfg = '0;
    want = '0;
    expansion = '0;
    cycle_start = 1'b0;
    counter_clear = '0;
    bounce = 1'b0;
    restart(1'b0, 1'b0, 1'b0);
    check({image, filtered_now, fast_counts[11:0]}, 48'h0, "reset state");
    check(fast_counts, 48'h0, "reset counts");
    dc_debounce;
    dc_fast;
    counters;
    ac_scan;
    ac_long;
    wrap_up;
  end

  initial begin
    repeat (100000) @(posedge sys_clk);
    miscompares++;
    wrap_up;
  end
endmodule : testbench
